/* File: hw/courtesy_light_sequencer.v */
// Courtesy light sequencer with AXI4-Lite control registers
`timescale 1ns/1ps
`include "courtesy_light_defines.vh"
module courtesy_light_sequencer #(
   parameter TICK_CYCLES = `CL_TICK_CYC,
   parameter FLASH_HALF  = `CL_FLASH_HALF_S
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        activation_accepted,
   input  wire        pre_delay,
   input  wire        moving,
   input  wire        manual_move,
   input  wire        stationary,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire        dry_contact_output,
   output wire        spare_open_drain_io_line_o,
   output wire        spare_open_drain_io_line_oe,
   output wire        aux_open_drain_o,
   output wire        aux_open_drain_oe,
   output wire        status_led_drive
);
   // Register map
   // CTRL at 0x0
   //    Bit 0: feature enable
   //    Bits 5:4: output select
   //       0 dry contact
   //       1 spare open-drain line
   //       2 aux open-drain line
   //       3 status LED drive
   //    Bits 9:8: profile select
   //       0 steady courtesy
   //       1 motion only
   //       2 flashing prewarn
   //       3 steady prewarn
   // HOLD at 0x4
   //    Bits 15:0: hold time in seconds
   //    Writes clamped into 4 to 35999
   //    Clamping chosen over refusal,
   //    so a stray write still leaves
   //    a usable hold time behind
   // STATUS at 0x8, read only
   //    Bits 3:0: sequencer state
   //    Bit 4: light level before routing
   //    Bits 31:16: seconds of hold left
   // Other offsets answer with SLVERR
   //
   // Bus timing
   // Ready signals are combinational
   // Address and data taken in any order
   // Response one cycle after the later
   // Channel refused once taken, until
   // its response has been accepted
   // Read data one cycle after address
   // Read address refused while rvalid
   //
   // Sequencer behaviour
   // Idle: nothing pending, light dark
   //    for the steady courtesy profile
   // Run: activation, pre-delay or
   //    powered motion in progress
   // Hold: barrier at rest after powered
   //    motion, countdown in seconds
   // Manual: barrier pushed by hand,
   //    no hold afterwards
   //
   // Latency
   // Barrier inputs to state: one cycle
   // State to pins: one more cycle
   // Direct input profiles: one cycle
   // Pins are registered so a change of
   //    selector never glitches a relay
   //
   // Hazards
   // Tick restarts on entering hold, so
   //    the first second is a whole one
   // Renewed motion during hold returns
   //    to run and reloads the count
   // Hold value written during hold is
   //    used from the next hold onward
   // Disabling the feature darkens the
   //    pins within two cycles
   // Flashing runs free from the start
   //    of each burst, always lit first
   // Flash rate is a fixed parameter,
   //    not reachable from software
   //
   // Limitations
   // Only the low two strobe lanes of
   //    each register are honoured
   // Open-drain data pins stay low; the
   //    enable alone switches the load
   // Manual motion with powered motion
   //    counts as manual
   // Inputs assumed already synchronous
   //    to the system clock
   //
   // Sequencer states, one-hot
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_RUN  = 4'b0010;
   localparam [3:0] ST_HOLD = 4'b0100;
   localparam [3:0] ST_MAN  = 4'b1000;

   // Control registers
   reg        enable_q;
   reg [1:0]  out_sel_q;
   reg [1:0]  profile_q;
   reg [15:0] hold_q;

   // Sequencer state
   reg [3:0]  state_q;
   reg [3:0]  state_d;
   reg [15:0] hold_cnt_q;
   reg        light;
   wire       tick;
   wire       hold_clear;

   // Open-drain pins only ever pull low
   assign spare_open_drain_io_line_o = 1'b0;
   assign aux_open_drain_o           = 1'b0;

   // AXI write side: both channels held until the response is taken
   reg  aw_seen_q;
   reg  w_seen_q;
   reg  [3:0]  aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire  = s_axi_wvalid & s_axi_wready;
   wire have_aw = aw_seen_q | aw_fire;
   wire have_w  = w_seen_q | w_fire;
   wire do_wr   = have_aw & have_w & ~s_axi_bvalid;
   wire [3:0]  wa = aw_seen_q ? aw_addr_q : s_axi_awaddr;
   wire [31:0] wd = w_seen_q ? w_data_q : s_axi_wdata;
   wire [3:0]  ws = w_seen_q ? w_strb_q : s_axi_wstrb;

   assign s_axi_awready = ~aw_seen_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_seen_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   // Clamp hold writes into the legal range rather than refuse them
   wire [15:0] hold_wr = {ws[1] ? wd[15:8] : hold_q[15:8],
                          ws[0] ? wd[7:0]  : hold_q[7:0]};
   wire [15:0] hold_clamped =
      (hold_wr < `CL_HOLD_MIN) ? `CL_HOLD_MIN :
      (hold_wr > `CL_HOLD_MAX) ? `CL_HOLD_MAX : hold_wr;

   // Write address/data capture and register update
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_seen_q    <= 1'b0;
         w_seen_q     <= 1'b0;
         aw_addr_q    <= 4'h0;
         w_data_q     <= 32'h0;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CL_RESP_OKAY;
         enable_q     <= 1'b0;
         out_sel_q    <= `CL_OUT_DRY;
         profile_q    <= `CL_PROF_STEADY;
         hold_q       <= `CL_HOLD_RST;
      end else begin
         if (aw_fire && !have_w) begin
            aw_seen_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_fire && !have_aw) begin
            w_seen_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_seen_q    <= 1'b0;
            w_seen_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `CL_RESP_OKAY;
            if (wa == `CL_CTRL_OFS) begin
               if (ws[0])
                  enable_q <= wd[`CL_EN_BIT];
               if (ws[0])
                  out_sel_q <= wd[`CL_OUT_LSB+1:`CL_OUT_LSB];
               if (ws[1])
                  profile_q <= wd[`CL_PROF_LSB+1:`CL_PROF_LSB];
            end else if (wa == `CL_HOLD_OFS) begin
               hold_q <= hold_clamped;
            end else if (wa == `CL_STAT_OFS) begin
               s_axi_bresp <= `CL_RESP_OKAY; // Read-only, write ignored
            end else begin
               s_axi_bresp <= `CL_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read side: one cycle from address to data
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `CL_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `CL_RESP_OKAY;
         if (s_axi_araddr == `CL_CTRL_OFS) begin
            s_axi_rdata <= {22'h0, profile_q, 2'h0, out_sel_q,
                            3'h0, enable_q};
         end else if (s_axi_araddr == `CL_HOLD_OFS) begin
            s_axi_rdata <= {16'h0, hold_q};
         end else if (s_axi_araddr == `CL_STAT_OFS) begin
            s_axi_rdata <= {hold_cnt_q, 11'h0, light, state_q};
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `CL_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Tick held clear outside hold and restarts on entering it, so hold is whole seconds
   assign hold_clear = (state_q != ST_HOLD);

   sec_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clear   (hold_clear),
      .tick    (tick)
   );

   // Next state: powered motion ends in hold, manual motion does not
   wire busy = moving | pre_delay | activation_accepted;
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (manual_move)
               state_d = ST_MAN;
            else if (busy)
               state_d = ST_RUN;
         end
         ST_RUN: begin
            if (manual_move)
               state_d = ST_MAN;
            else if (!busy && stationary)
               state_d = ST_HOLD;
         end
         ST_HOLD: begin
            if (busy)
               state_d = ST_RUN;
            else if (manual_move)
               state_d = ST_MAN;
            else if (tick && hold_cnt_q <= 16'h1)
               state_d = ST_IDLE;
         end
         ST_MAN: begin
            if (busy && !manual_move)
               state_d = ST_RUN;
            else if (!manual_move && stationary)
               state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // State register and hold countdown in seconds
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ST_IDLE;
         hold_cnt_q <= 16'h0;
      end else begin
         state_q <= state_d;
         if (state_q != ST_HOLD)
            hold_cnt_q <= hold_q;
         else if (tick && hold_cnt_q != 16'h0)
            hold_cnt_q <= hold_cnt_q - 16'h1;
      end
   end

   // Half-period divider for flashing, about 50 % duty
   reg [31:0] fdiv_q;
   reg        fph_q;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fdiv_q <= 32'h0;
         fph_q  <= 1'b1;
      end else if (!(moving | pre_delay)) begin
         fdiv_q <= 32'h0;
         fph_q  <= 1'b1;
      end else if (fdiv_q == FLASH_HALF * TICK_CYCLES / 2 - 1) begin
         fdiv_q <= 32'h0;
         fph_q  <= ~fph_q;
      end else begin
         fdiv_q <= fdiv_q + 32'h1;
      end
   end

   // Profile decode; enable gates everything
   always @* begin
      light = 1'b0;
      case (profile_q)
         `CL_PROF_STEADY:
            light = (state_q == ST_RUN) || (state_q == ST_HOLD) ||
                    activation_accepted;
         `CL_PROF_MOT:
            light = moving & ~manual_move;
         `CL_PROF_FLS:
            light = (moving | pre_delay) & fph_q;
         `CL_PROF_STP:
            light = moving | pre_delay;
         default: light = 1'b0;
      endcase
      if (!enable_q)
         light = 1'b0;
   end

   out_route u_route (
      .ref_clk                     (ref_clk),
      .rst_n                       (rst_n),
      .light                       (light),
      .sel                         (out_sel_q),
      .dry_contact_output          (dry_contact_output),
      .spare_open_drain_io_line_oe (spare_open_drain_io_line_oe),
      .aux_open_drain_oe           (aux_open_drain_oe),
      .status_led_drive            (status_led_drive)
   );
endmodule

/* File: hw/courtesy_light_defines.vh */
// Register map, fields, defaults and timing for the courtesy light block
// How it works
// - Disabled feature forces selected output inactive
// - Reset leaves the feature disabled
// - Light routed to exactly one output
// - Four profile encodings, one governs
// - Steady profile: activation turns light on
// - Steady profile: on while moving, pre-delay
// - Steady profile: hold time then off
// - Motion-only profile: on only while moving
// - Flashing profile: toggles moving and pre-delay
// - Steady prewarn: same states, no flashing
// - Hold phase after powered rest only
// - Hold time 4 s to 35999 s
`ifndef COURTESY_LIGHT_DEFINES_VH
`define COURTESY_LIGHT_DEFINES_VH
`define CL_ADDR_W        4
`define CL_CTRL_OFS      4'h0
`define CL_HOLD_OFS      4'h4
`define CL_STAT_OFS      4'h8
`define CL_EN_BIT        0
`define CL_OUT_LSB       4
`define CL_PROF_LSB      8
`define CL_OUT_DRY       2'h0
`define CL_OUT_SPARE     2'h1
`define CL_OUT_AUX       2'h2
`define CL_OUT_LED       2'h3
`define CL_PROF_STEADY   2'h0
`define CL_PROF_MOT      2'h1
`define CL_PROF_FLS      2'h2
`define CL_PROF_STP      2'h3
`define CL_HOLD_MIN      16'h0004
`define CL_HOLD_MAX      16'h8c9f
`define CL_HOLD_RST      16'h003c
`define CL_CLK_HZ        40000000
`define CL_TICK_CYC      40000000
`define CL_FLASH_HALF_S  1
`define CL_RESP_OKAY     2'h0
`define CL_RESP_SLVERR   2'h2
`endif

/* File: hw/sec_tick.v */
// One-second tick generator from the system clock
`timescale 1ns/1ps
`include "courtesy_light_defines.vh"
module sec_tick #(
   parameter CYCLES = `CL_TICK_CYC
) (
   input  wire ref_clk,
   input  wire rst_n,
   input  wire clear,
   output reg  tick
);
   reg [31:0] cnt_q;
   // Free running divider, restartable so hold counts whole seconds
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 32'h0;
         tick  <= 1'b0;
      end else if (clear) begin
         cnt_q <= 32'h0;
         tick  <= 1'b0;
      end else if (cnt_q == CYCLES - 1) begin
         cnt_q <= 32'h0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         tick  <= 1'b0;
      end
   end
endmodule

/* File: hw/out_route.v */
// Routes the light level to one of four physical outputs
`timescale 1ns/1ps
`include "courtesy_light_defines.vh"
module out_route (
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire       light,
   input  wire [1:0] sel,
   output reg        dry_contact_output,
   output reg        spare_open_drain_io_line_oe,
   output reg        aux_open_drain_oe,
   output reg        status_led_drive
);
   // Registered so pins never glitch while the selector changes
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dry_contact_output          <= 1'b0;
         spare_open_drain_io_line_oe <= 1'b0;
         aux_open_drain_oe           <= 1'b0;
         status_led_drive            <= 1'b0;
      end else begin
         dry_contact_output          <= light & (sel == `CL_OUT_DRY);
         spare_open_drain_io_line_oe <= light & (sel == `CL_OUT_SPARE);
         aux_open_drain_oe           <= light & (sel == `CL_OUT_AUX);
         status_led_drive            <= light & (sel == `CL_OUT_LED);
      end
   end
endmodule

/* File: testbench/light_load_model.sv */
// External lamp load hung on the four light outputs
`timescale 1ns/1ps
module light_load (
   input  wire dry,
   input  wire sp_o,
   input  wire sp_oe,
   input  wire ax_o,
   input  wire ax_oe,
   input  wire led,
   output wire lamp
);
   // Released open-drain lines float high on the pull-up
   wire sp_line = sp_oe ? sp_o : 1'h1;
   wire ax_line = ax_oe ? ax_o : 1'h1;
   // Any closed or sinking path lights the lamp
   assign lamp = dry | !sp_line | !ax_line | led;
endmodule

/* File: testbench/courtesy_light_sva.sv */
// Checker for light routing and profile behaviour at the ports
`timescale 1ns/1ps
module courtesy_light_sva #(
   parameter TICK_CYCLES = 20,
   parameter FLASH_HALF  = 1
) (
   input wire        ref_clk,
   input wire        rst_n,
   input wire        pre_delay,
   input wire        moving,
   input wire [3:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        dry_contact_output,
   input wire        spare_open_drain_io_line_o,
   input wire        spare_open_drain_io_line_oe,
   input wire        aux_open_drain_o,
   input wire        aux_open_drain_oe,
   input wire        status_led_drive
);
   localparam int HALF = FLASH_HALF * TICK_CYCLES / 2;
   logic [4:0] cfg_q, cfg_p;
   logic       lit_q;
   int         flat_q;
   wire [3:0]  outs = {status_led_drive, aux_open_drain_oe,
                       spare_open_drain_io_line_oe, dry_contact_output};
   wire        lit = |outs;
   wire        en = cfg_q[4];
   wire [1:0]  sel = cfg_q[3:2];
   wire [1:0]  prof = cfg_q[1:0];
   wire        calm = (cfg_q == cfg_p);
   wire        fl_on = en && prof == 2'h2 && (moving || pre_delay);
   // Shadow of the control word; a write lands when both channels meet
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q  <= 5'h00;
         cfg_p  <= 5'h00;
         lit_q  <= 1'h0;
         flat_q <= 0;
      end else begin
         if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
             s_axi_wready && s_axi_awaddr == 4'h0)
            cfg_q <= {s_axi_wdata[0], s_axi_wdata[5:4], s_axi_wdata[9:8]};
         cfg_p  <= cfg_q;
         lit_q  <= lit;
         // Cycles without a light edge while flashing is due
         flat_q <= (fl_on && lit == lit_q) ? flat_q + 1 : 0;
      end
   end
   // Config must sit still two cycles, as the output is registered
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_off_dark: assert property (!en && calm && $past(calm) |-> !lit)
      else $error("light driven while disabled");
   a_one_out: assert property ($onehot0(outs))
      else $error("more than one light output active");
   a_od_low: assert property (!spare_open_drain_io_line_o &&
      !aux_open_drain_o) else $error("open-drain data not low");
   a_route_sel: assert property (lit && calm && $past(calm)
      |-> outs == 4'h1 << sel) else $error("light on wrong output");
   a_motion_only: assert property (en && prof == 2'h1 && calm &&
      $past(calm) && $past(!moving) |-> !lit) else $error("lit at rest");
   a_steady_on: assert property (en && prof == 2'h0 && calm &&
      $past(calm) && $past(moving || pre_delay) &&
      $past(moving || pre_delay, 2) |-> lit)
      else $error("steady light dark in motion");
   a_prewarn_on: assert property (en && prof == 2'h3 && calm &&
      $past(calm) && $past(moving || pre_delay) &&
      (moving || pre_delay) |-> lit ##1 lit)
      else $error("prewarn light not steady");
   a_prewarn_off: assert property (en && prof == 2'h3 && calm &&
      $past(calm) && $past(!moving && !pre_delay) |-> !lit)
      else $error("prewarn light on outside motion");
   a_flash_runs: assert property (flat_q <= HALF + 3)
      else $error("flashing light stuck");
endmodule
bind courtesy_light_sequencer courtesy_light_sva #(
   .TICK_CYCLES(TICK_CYCLES), .FLASH_HALF(FLASH_HALF)) u_sva (
   .ref_clk, .rst_n, .pre_delay, .moving, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
   .dry_contact_output, .spare_open_drain_io_line_o,
   .spare_open_drain_io_line_oe, .aux_open_drain_o, .aux_open_drain_oe,
   .status_led_drive);

/* File: testbench/testbench.sv */
// Self-checking bench for the courtesy light sequencer
`timescale 1ns/1ps
module testbench;
   localparam int TICK = 20;
   // Codes per profile and phase: 0 dark, 1 steady, 2 flashing
   localparam logic [23:0] TAB = 24'h14a115;
   logic        ref_clk = 1'h0, rst_n = 1'h0, act = 1'h0, pre = 1'h0;
   logic        mov = 1'h0, man = 1'h0, sta = 1'h1, awv = 1'h0;
   logic        wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
   logic [3:0]  awa = 4'h0, ara = 4'h0;
   logic [31:0] wd = 32'h0, c;
   logic [15:0] h;
   wire         awr, wrr, bv, arr, rv, dry, spo, spoe, axo, axoe, led, lamp;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   int          n_fail = 0, total_checks = 0;
   logic [33:0] exp_q [$];
   // 40 MHz system clock
   always #12.5 ref_clk = ~ref_clk;
   courtesy_light_sequencer #(.TICK_CYCLES(TICK), .FLASH_HALF(1)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .activation_accepted(act),
      .pre_delay(pre), .moving(mov), .manual_move(man), .stationary(sta),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .dry_contact_output(dry),
      .spare_open_drain_io_line_o(spo), .spare_open_drain_io_line_oe(spoe),
      .aux_open_drain_o(axo), .aux_open_drain_oe(axoe),
      .status_led_drive(led));
   light_load u_load (.dry(dry), .sp_o(spo), .sp_oe(spoe), .ax_o(axo),
                      .ax_oe(axoe), .led(led), .lamp(lamp));
   // Comparison helpers and the single exit
   task chk_pin(input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task chk_rd(input logic [33:0] e, input logic [33:0] g);
      chk_pin(e[31:0], g[31:0]);
      chk_pin(32'(e[33:32]), 32'(g[33:32]));
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Write: both channels offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic ad = 1'h0, dd = 1'h0;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      for (int k = 0; k < 60; k++) begin
         @(posedge ref_clk);
         if (ad && dd && bv) break;
         ad = ad | awr;
         dd = dd | wrr;
         awv <= !ad;
         wv <= !dd;
      end
      br <= 1'h0;
      @(posedge ref_clk);
   endtask
   // Read: expectation noted first, the watcher compares on rvalid
   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      for (int k = 0; k < 60; k++) begin
         @(posedge ref_clk);
         if (rv) break;
         if (arr) arv <= 1'h0;
      end
      rr <= 1'h0;
      @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      if (rv === 1'h1 && rr && exp_q.size() > 0)
         chk_rd(exp_q.pop_front(), {rresp, rdata});
   end
   // One barrier phase; lamp sampled 40 cycles and reduced to a code
   task automatic ph(input logic p, input logic m, output logic [31:0] cd);
      int on_n = 0, ch_n = 0;
      logic last;
      pre <= p;
      mov <= m;
      sta <= !p && !m;
      repeat (4) @(posedge ref_clk);
      last = lamp;
      for (int k = 0; k < 40; k++) begin
         @(posedge ref_clk);
         on_n += (lamp === 1'h1);
         ch_n += (lamp !== last);
         last = lamp;
      end
      cd = ch_n > 1 ? 2 : on_n == 40 ? 1 : on_n == 0 ? 0 : 3;
   endtask
   // Long enough for the whole sequence with wide margin
   initial begin
      #200us;
      n_fail++;
      close_out;
   end
   initial begin
      void'($urandom(77076));
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      rd(4'h0, 34'h0);
      rd(4'h4, 34'h3c);
      rd(4'hc, {2'h2, 32'h0});
      wr(4'h4, 32'h2);
      rd(4'h4, 34'h4);
      wr(4'h4, 32'hffff);
      rd(4'h4, 34'h8c9f);
      h = 16'h4 + 16'($urandom % 35996);
      wr(4'h4, {16'h0, h});
      rd(4'h4, {18'h0, h});
      wr(4'h4, 32'h4);
      ph(1'h0, 1'h1, c);
      chk_pin(32'h0, c);
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, 32'h1 | (i << 4));
         ph(1'h0, 1'h1, c);
         chk_pin(32'h1 << i, {28'h0, led, axoe, spoe, dry});
      end
      // Steady courtesy last, so its hold runs into the timer checks
      for (int p = 1; p < 5; p++) begin
         wr(4'h0, 32'h1 | ((p % 4) << 8));
         for (int f = 0; f < 3; f++) begin
            ph(f == 0, f == 1, c);
            chk_pin(32'((TAB >> (((p % 4) * 3 + f) * 2)) & 24'h3), c);
         end
      end
      ph(1'h0, 1'h1, c);
      ph(1'h0, 1'h0, c);
      ph(1'h0, 1'h1, c);
      ph(1'h0, 1'h0, c);
      chk_pin(32'h1, c);
      repeat (28) @(posedge ref_clk);
      chk_pin(32'h1, {31'h0, lamp});
      repeat (22) @(posedge ref_clk);
      chk_pin(32'h0, {31'h0, lamp});
      act <= 1'h1;
      @(posedge ref_clk);
      act <= 1'h0;
      repeat (3) @(posedge ref_clk);
      chk_pin(32'h1, {31'h0, lamp});
      repeat (120) @(posedge ref_clk);
      man <= 1'h1;
      sta <= 1'h0;
      repeat (10) @(posedge ref_clk);
      man <= 1'h0;
      sta <= 1'h1;
      repeat (10) @(posedge ref_clk);
      chk_pin(32'h0, {31'h0, lamp});
      ph(1'h0, 1'h1, c);
      wr(4'h0, 32'h0);
      ph(1'h0, 1'h1, c);
      chk_pin(32'h0, c);
      close_out;
   end
endmodule
